// file: design/reset_pkg.sv
// Constants, types and reset values for the reset state and supply supervisor.
package reset_pkg;

  localparam int          PC_W           = 14;
  localparam logic [13:0] PC_RST         = 14'h0000;
  localparam logic        FLAG_CLR       = 1'b0;
  localparam logic        WD_ALLOW_RST   = 1'b1;
  localparam logic [3:0]  IRQ_CTRL_RST   = 4'h0;
  localparam logic        PRESC_RST      = 1'b0;
  localparam logic [4:0]  TIMER_CTRL_RST = 5'h00;
  localparam logic [3:0]  DISP_TIMER_RST = 4'h0;
  localparam logic [3:0]  OSC_CTRL_RST   = 4'h8;
  localparam logic [3:0]  DISP_AB_RST    = 4'h0;
  localparam logic [3:0]  DISP_C_RST     = 4'hF;
  localparam logic [3:0]  PORT_CTRL_RST  = 4'h0;

  // Bit positions inside the write data for flag and watchdog writes.
  localparam int FLG_IRQ   = 0;
  localparam int FLG_EXT0  = 1;
  localparam int FLG_PD    = 2;
  localparam int FLG_HIREF = 3;
  localparam int WDG_ALLOW = 0;
  localparam int WDG_STA   = 1;
  localparam int WDG_STB   = 2;

  typedef enum logic [4:0] {
    SEL_IRQ_A  = 5'h00,
    SEL_IRQ_B  = 5'h01,
    SEL_FLAGS  = 5'h02,
    SEL_WDOG   = 5'h03,
    SEL_PRESC  = 5'h04,
    SEL_T1     = 5'h05,
    SEL_T2     = 5'h06,
    SEL_T3     = 5'h07,
    SEL_T4     = 5'h08,
    SEL_OSC    = 5'h09,
    SEL_DISP_A = 5'h0A,
    SEL_DISP_B = 5'h0B,
    SEL_DISP_C = 5'h0C,
    SEL_KEY    = 5'h0D,
    SEL_PU     = 5'h0E,
    SEL_FR     = 5'h0F
  } reg_sel_t;

  typedef enum logic [2:0] {
    ST_RUN  = 3'b001,
    ST_HOLD = 3'b010,
    ST_OSC  = 3'b100
  } bo_state_t;

  typedef struct packed {
    logic       en;
    reg_sel_t   sel;
    logic [1:0] idx;
    logic [4:0] data;
  } wr_req_t;

  typedef struct packed {
    logic en_pin;
    logic skip;
    logic rst;
    logic release_ok;
  } supply_cmp_t;

  typedef struct packed {
    logic [13:0]     pc;
    logic            global_irq_allow;
    logic            pd_flag;
    logic            ext_zero_irq_request;
    logic [3:0]      irq_source_ctrl_a;
    logic [3:0]      irq_source_ctrl_b;
    logic            watchdog_allow;
    logic            watchdog_status_a;
    logic            watchdog_status_b;
    logic            prescaler_ctrl;
    logic [4:0]      timer_one_ctrl;
    logic [4:0]      timer_two_ctrl;
    logic [4:0]      timer_three_ctrl;
    logic [3:0]      display_timer_ctrl;
    logic [3:0]      oscillator_ctrl;
    logic [3:0]      display_ctrl_a;
    logic [3:0]      display_ctrl_b;
    logic [3:0]      display_ctrl_c;
    logic [3:0][3:0] key_wake_ctrl;
    logic [3:0][3:0] pullup_ctrl;
    logic [3:0][3:0] port_structure_ctrl;
    logic            high_bit_reference_allow;
  } core_regs_t;

  localparam core_regs_t CORE_RST = '{
    pc:                       PC_RST,
    global_irq_allow:         FLAG_CLR,
    pd_flag:                  FLAG_CLR,
    ext_zero_irq_request:     FLAG_CLR,
    irq_source_ctrl_a:        IRQ_CTRL_RST,
    irq_source_ctrl_b:        IRQ_CTRL_RST,
    watchdog_allow:           WD_ALLOW_RST,
    watchdog_status_a:        FLAG_CLR,
    watchdog_status_b:        FLAG_CLR,
    prescaler_ctrl:           PRESC_RST,
    timer_one_ctrl:           TIMER_CTRL_RST,
    timer_two_ctrl:           TIMER_CTRL_RST,
    timer_three_ctrl:         TIMER_CTRL_RST,
    display_timer_ctrl:       DISP_TIMER_RST,
    oscillator_ctrl:          OSC_CTRL_RST,
    display_ctrl_a:           DISP_AB_RST,
    display_ctrl_b:           DISP_AB_RST,
    display_ctrl_c:           DISP_C_RST,
    key_wake_ctrl:            {4{PORT_CTRL_RST}},
    pullup_ctrl:              {4{PORT_CTRL_RST}},
    port_structure_ctrl:      {4{PORT_CTRL_RST}},
    high_bit_reference_allow: FLAG_CLR
  };

endpackage

// file: design/level_sync.sv
// Two-flop synchroniser for a group of asynchronous level inputs.
`timescale 1ns/100ps
module level_sync #(
  parameter int N = 4
) (
  input  wire logic         clk_i,
  input  wire logic         sys_rst_i,
  input  wire logic [N-1:0] d_i,
  output logic      [N-1:0] q_o
);

  logic [N-1:0] meta_q;
  logic [N-1:0] sync_q;

  for (genvar i = 0; i < N; i++) begin : g_bit
    always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
        meta_q[i] <= 1'b0;
        sync_q[i] <= 1'b0;
      end else begin
        meta_q[i] <= d_i[i];
        sync_q[i] <= meta_q[i];
      end
    end
  end

  assign q_o = sync_q;

endmodule

// file: design/reset_state_brownout.sv
// Reset state of the core control registers and the supply-drop supervisor.
`timescale 1ns/100ps
module reset_state_brownout
  import reset_pkg::*;
(
  input  wire logic        clk_i,
  input  wire supply_cmp_t supply_i,
  input  wire logic        sys_rst_i,
  input  wire logic        power_down_i,
  input  wire logic        hold_instr_i,
  input  wire logic        skip_test_i,
  input  wire logic        ext0_event_i,
  input  wire wr_req_t     wr_i,
  input  wire logic        pc_load_i,
  input  wire logic [13:0] pc_value_i,
  output core_regs_t       core_o,
  output logic             supervisor_active_o,
  output logic             low_voltage_flag_o,
  output logic             skip_next_o,
  output logic             supervisor_reset_o,
  output logic             osc_enable_o
);

  typedef struct packed {
    core_regs_t core;
    logic       hold;
    logic       lv_flag;
    logic       sv_active;
    logic       skip_next;
    logic       bo_rst;
    logic       osc_en;
    bo_state_t  st;
    logic       pd_prev;
  } state_t;

  state_t      q;
  state_t      d;
  supply_cmp_t sup_s;
  logic        sys_reset;

  // Comparator outputs and the enable pin come from the analog side.
  level_sync #(
    .N(4)
  ) u_sync (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .d_i       (supply_i),
    .q_o       (sup_s)
  );

  // The block's own brown-out reset resets the core just like the pin does.
  assign sys_reset = sys_rst_i | q.bo_rst;

  always_comb begin
    d           = q;
    d.skip_next = 1'b0;
    d.pd_prev   = power_down_i;

    if (wr_i.en) begin
      case (wr_i.sel)
        SEL_IRQ_A: begin
          d.core.irq_source_ctrl_a = wr_i.data[3:0];
        end
        SEL_IRQ_B: begin
          d.core.irq_source_ctrl_b = wr_i.data[3:0];
        end
        SEL_FLAGS: begin
          d.core.global_irq_allow         = wr_i.data[FLG_IRQ];
          d.core.ext_zero_irq_request     = wr_i.data[FLG_EXT0];
          d.core.pd_flag                  = wr_i.data[FLG_PD];
          d.core.high_bit_reference_allow = wr_i.data[FLG_HIREF];
        end
        SEL_WDOG: begin
          d.core.watchdog_allow    = wr_i.data[WDG_ALLOW];
          d.core.watchdog_status_a = wr_i.data[WDG_STA];
          d.core.watchdog_status_b = wr_i.data[WDG_STB];
        end
        SEL_PRESC: begin
          d.core.prescaler_ctrl = wr_i.data[0];
        end
        SEL_T1: begin
          d.core.timer_one_ctrl = wr_i.data;
        end
        SEL_T2: begin
          d.core.timer_two_ctrl = wr_i.data;
        end
        SEL_T3: begin
          d.core.timer_three_ctrl = wr_i.data;
        end
        SEL_T4: begin
          d.core.display_timer_ctrl = wr_i.data[3:0];
        end
        SEL_OSC: begin
          d.core.oscillator_ctrl = wr_i.data[3:0];
        end
        SEL_DISP_A: begin
          d.core.display_ctrl_a = wr_i.data[3:0];
        end
        SEL_DISP_B: begin
          d.core.display_ctrl_b = wr_i.data[3:0];
        end
        SEL_DISP_C: begin
          d.core.display_ctrl_c = wr_i.data[3:0];
        end
        SEL_KEY: begin
          d.core.key_wake_ctrl[wr_i.idx] = wr_i.data[3:0];
        end
        SEL_PU: begin
          d.core.pullup_ctrl[wr_i.idx] = wr_i.data[3:0];
        end
        SEL_FR: begin
          d.core.port_structure_ctrl[wr_i.idx] = wr_i.data[3:0];
        end
        default: begin
        end
      endcase
    end

    if (pc_load_i) begin
      d.core.pc = pc_value_i;
    end

    // Hardware events are applied after writes so that a set wins a clear.
    if (ext0_event_i) begin
      d.core.ext_zero_irq_request = 1'b1;
    end
    if (q.pd_prev & ~power_down_i) begin
      d.core.pd_flag = 1'b1;
    end

    if (hold_instr_i) begin
      d.hold = 1'b1;
    end

    d.sv_active = sup_s.en_pin & (~power_down_i | q.hold);
    // Without the hold the supervisor is off in power down.
    // With the hold it keeps watching through power down.
    d.lv_flag = d.sv_active & sup_s.skip;

    if (skip_test_i) begin
      d.skip_next = q.lv_flag;
    end

    case (q.st)
      ST_RUN: begin
        if (d.sv_active & sup_s.rst) begin
          d.st     = ST_HOLD;
          d.bo_rst = 1'b1;
          d.osc_en = 1'b0;
        end
      end
      ST_HOLD: begin
        d.bo_rst = 1'b1;
        if (~d.sv_active | (sup_s.release_ok & ~sup_s.rst)) begin
          d.st     = ST_OSC;
          d.osc_en = 1'b1;
        end
      end
      ST_OSC: begin
        if (d.sv_active & sup_s.rst) begin
          d.st     = ST_HOLD;
          d.osc_en = 1'b0;
        end else begin
          d.st     = ST_RUN;
          d.bo_rst = 1'b0;
        end
      end
      default: begin
        d.st     = ST_HOLD;
        d.bo_rst = 1'b1;
        d.osc_en = 1'b0;
      end
    endcase

    if (sys_reset) begin
      d.core      = CORE_RST;
      d.hold      = 1'b0;
      d.skip_next = 1'b0;
    end

    if (sys_rst_i) begin
      d.st        = ST_RUN;
      d.bo_rst    = 1'b0;
      d.osc_en    = 1'b1;
      d.lv_flag   = 1'b0;
      d.sv_active = 1'b0;
      d.pd_prev   = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    q <= d;
  end

  assign core_o              = q.core;
  assign supervisor_active_o = q.sv_active;
  assign low_voltage_flag_o  = q.lv_flag;
  assign skip_next_o         = q.skip_next;
  assign supervisor_reset_o  = q.bo_rst;
  assign osc_enable_o        = q.osc_en;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence s_brown_trip;
    q.st == ST_RUN && sup_s.en_pin && sup_s.rst &&
      (!power_down_i || q.hold);
  endsequence

  sequence s_release;
    q.st == ST_HOLD ##1 q.st == ST_OSC;
  endsequence

  a_pc_zero: assert property (
    q.bo_rst |=> core_o.pc == PC_RST
  ) else $error("program counter not cleared by reset");

  a_irq_flags_clear: assert property (
    q.bo_rst |=> !core_o.global_irq_allow && !core_o.pd_flag &&
      !core_o.ext_zero_irq_request
  ) else $error("interrupt flags not cleared by reset");

  a_irq_src_clear: assert property (
    q.bo_rst |=> core_o.irq_source_ctrl_a == IRQ_CTRL_RST &&
      core_o.irq_source_ctrl_b == IRQ_CTRL_RST
  ) else $error("interrupt source controls not cleared");

  a_wdog_reset: assert property (
    q.bo_rst |=> core_o.watchdog_allow && !core_o.watchdog_status_a &&
      !core_o.watchdog_status_b
  ) else $error("watchdog reset state wrong");

  a_timers_stop: assert property (
    q.bo_rst |=> !core_o.prescaler_ctrl &&
      core_o.timer_one_ctrl == TIMER_CTRL_RST &&
      core_o.timer_two_ctrl == TIMER_CTRL_RST &&
      core_o.timer_three_ctrl == TIMER_CTRL_RST &&
      core_o.display_timer_ctrl == DISP_TIMER_RST
  ) else $error("timer controls not cleared");

  a_osc_pattern: assert property (
    q.bo_rst |=> core_o.oscillator_ctrl == OSC_CTRL_RST
  ) else $error("oscillator control reset pattern wrong");

  a_disp_init: assert property (
    q.bo_rst |=> core_o.display_ctrl_a == DISP_AB_RST &&
      core_o.display_ctrl_b == DISP_AB_RST &&
      core_o.display_ctrl_c == DISP_C_RST
  ) else $error("display controls reset wrong");

  a_port_clear: assert property (
    q.bo_rst |=> core_o.key_wake_ctrl == '0 && core_o.pullup_ctrl == '0 &&
      core_o.port_structure_ctrl == '0
  ) else $error("port controls not cleared");

  a_hiref_clear: assert property (
    q.bo_rst |=> !core_o.high_bit_reference_allow
  ) else $error("high bit reference flag not cleared");

  a_pin_gates: assert property (
    !sup_s.en_pin |=> !supervisor_active_o && !low_voltage_flag_o
  ) else $error("supervisor active with enable pin low");

  a_pd_sleep: assert property (
    sup_s.en_pin && power_down_i && !q.hold |=> !supervisor_active_o
  ) else $error("supervisor active in power down without hold");

  a_pd_hold: assert property (
    sup_s.en_pin && q.hold && !q.bo_rst |=> supervisor_active_o
  ) else $error("supervisor asleep despite hold");

  a_hold_forget: assert property (
    q.bo_rst |=> !q.hold
  ) else $error("hold state survived reset");

  a_flag_track: assert property (
    supervisor_active_o |-> low_voltage_flag_o == $past(sup_s.skip)
  ) else $error("low voltage flag does not follow supply");

  a_skip_keep: assert property (
    skip_test_i && !q.bo_rst |=> skip_next_o == $past(low_voltage_flag_o) &&
      low_voltage_flag_o == (supervisor_active_o && $past(sup_s.skip))
  ) else $error("skip test result or flag wrong");

  a_brown_trip: assert property (
    s_brown_trip |=> supervisor_reset_o [*2]
  ) else $error("brown-out did not assert system reset");

  a_release_order: assert property (
    s_release |-> osc_enable_o && supervisor_reset_o
  ) else $error("reset released before oscillator enabled");

  sequence s_osc_exit;
    q.st == ST_OSC && !sup_s.rst;
  endsequence

  a_release_run: assert property (
    s_osc_exit |=> !supervisor_reset_o && osc_enable_o
  ) else $error("reset not released after oscillator step");

  a_held_osc_off: assert property (
    q.st == ST_HOLD |-> !osc_enable_o && supervisor_reset_o
  ) else $error("oscillator enabled while brown-out reset held");

  a_pd_return: assert property (
    sup_s.en_pin && !power_down_i |=> supervisor_active_o
  ) else $error("supervisor not active in operation with pin high");

  a_hold_kept: assert property (
    q.hold && !q.bo_rst |=> q.hold
  ) else $error("hold state lost without reset");

  a_skip_idle: assert property (
    !skip_test_i |=> !skip_next_o
  ) else $error("skip raised without a skip test");

  a_flag_inactive: assert property (
    !supervisor_active_o |-> !low_voltage_flag_o
  ) else $error("low voltage flag set while supervisor inactive");

  a_write_refused: assert property (
    q.bo_rst && wr_i.en |=> core_o.oscillator_ctrl == OSC_CTRL_RST
  ) else $error("register write taken during brown-out reset");

endmodule

// file: testbench/reset_state_and_brownout_logic_bench.sv
// Self-checking bench for the reset state and supply supervisor block.
`timescale 1ns/100ps
module reset_state_and_brownout_logic_bench;
  import reset_pkg::*;

  logic        clk_i;
  logic        sys_rst_i;
  supply_cmp_t supply_i;
  logic        power_down_i;
  logic        hold_instr_i;
  logic        skip_test_i;
  logic        ext0_event_i;
  wr_req_t     wr_i;
  logic        pc_load_i;
  logic [13:0] pc_value_i;
  core_regs_t  core_o;
  logic        supervisor_active_o;
  logic        low_voltage_flag_o;
  logic        skip_next_o;
  logic        supervisor_reset_o;
  logic        osc_enable_o;
  int          failures;
  int          check_count;
  int          cycles;
  int          seed;
  logic [3:0]  exp_osc;
  logic [4:0]  last_wr [16][4];
  logic [3:0]  rnd;
  logic        exp_act;

  reset_state_brownout i_reset_state_brownout (
    .clk_i               (clk_i),
    .supply_i            (supply_i),
    .sys_rst_i           (sys_rst_i),
    .power_down_i        (power_down_i),
    .hold_instr_i        (hold_instr_i),
    .skip_test_i         (skip_test_i),
    .ext0_event_i        (ext0_event_i),
    .wr_i                (wr_i),
    .pc_load_i           (pc_load_i),
    .pc_value_i          (pc_value_i),
    .core_o              (core_o),
    .supervisor_active_o (supervisor_active_o),
    .low_voltage_flag_o  (low_voltage_flag_o),
    .skip_next_o         (skip_next_o),
    .supervisor_reset_o  (supervisor_reset_o),
    .osc_enable_o        (osc_enable_o)
  );

  initial clk_i = 1'b0;
  always #10 clk_i = ~clk_i;

  task automatic complete_run();
    if (failures == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // A run that hangs is cut short and counted as a mismatch.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      complete_run();
    end
  end

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Supervisor activity: pin high, and either running or held.
  function automatic logic exp_active(input logic en, input logic pd,
                                      input logic hold);
    return en & (~pd | hold);
  endfunction

  // Expected contents of a four-entry register bank after the writes.
  function automatic logic [15:0] exp_bank(input int s);
    return {last_wr[s][3][3:0], last_wr[s][2][3:0], last_wr[s][1][3:0],
            last_wr[s][0][3:0]};
  endfunction

  task automatic check_reset_state();
    check("pc", core_o.pc, 16'h0000);
    check("flags", {core_o.global_irq_allow, core_o.pd_flag,
          core_o.ext_zero_irq_request}, 16'h0000);
    check("irq", {core_o.irq_source_ctrl_a, core_o.irq_source_ctrl_b},
          16'h0000);
    check("wdog", {core_o.watchdog_allow, core_o.watchdog_status_a,
          core_o.watchdog_status_b}, 16'h0004);
    check("timers", {core_o.prescaler_ctrl, core_o.timer_one_ctrl,
          core_o.timer_two_ctrl, core_o.timer_three_ctrl,
          core_o.display_timer_ctrl}, 16'h0000);
    check("osc", core_o.oscillator_ctrl, 16'h0008);
    check("disp", {core_o.display_ctrl_a, core_o.display_ctrl_b,
          core_o.display_ctrl_c}, 16'h000F);
    check("key", core_o.key_wake_ctrl, 16'h0000);
    check("pu", core_o.pullup_ctrl, 16'h0000);
    check("fr", core_o.port_structure_ctrl, 16'h0000);
    check("hiref", core_o.high_bit_reference_allow, 16'h0000);
  endtask

  task automatic do_reset();
    @(negedge clk_i);
    sys_rst_i = 1'b1;
    repeat (5) @(negedge clk_i);
    check_reset_state();
    sys_rst_i = 1'b0;
  endtask

  // Supply comparator changes need two sync flops plus one register.
  task automatic settle();
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  task automatic wr(input reg_sel_t sel, input logic [1:0] idx,
                    input logic [4:0] data);
    @(negedge clk_i);
    wr_i = '{en: 1'b1, sel: sel, idx: idx, data: data};
  endtask

  task automatic wr_idle();
    @(negedge clk_i);
    wr_i.en = 1'b0;
  endtask

  task automatic pulse(ref logic sig);
    @(negedge clk_i);
    sig = 1'b1;
    @(negedge clk_i);
    sig = 1'b0;
  endtask

  task automatic set_supply(input logic en, input logic skip,
                            input logic rst, input logic rel);
    @(negedge clk_i);
    supply_i = '{en_pin: en, skip: skip, rst: rst, release_ok: rel};
    settle();
  endtask

  initial begin
    failures = 0;
    check_count = 0;
    cycles = 0;
    seed = 32'ha019;
    sys_rst_i = 1'b0;
    supply_i = '{en_pin: 1'b0, skip: 1'b0, rst: 1'b0, release_ok: 1'b1};
    power_down_i = 1'b0;
    hold_instr_i = 1'b0;
    skip_test_i = 1'b0;
    ext0_event_i = 1'b0;
    wr_i = '0;
    pc_load_i = 1'b0;
    pc_value_i = 14'h0000;
    do_reset();
    // Back-to-back random writes to every register, then reset again.
    for (int s = 0; s < 16; s++) begin
      for (int i = 0; i < 4; i++) begin
        wr(reg_sel_t'(s), 2'(i), 5'($random(seed)));
        last_wr[s][i] = wr_i.data;
        if (s == 9)
          exp_osc = wr_i.data[3:0];
      end
    end
    wr(SEL_FLAGS, 2'h0, 5'h1F);
    wr_idle();
    @(negedge clk_i);
    check("osc_wr", core_o.oscillator_ctrl, exp_osc);
    check("key_wr", core_o.key_wake_ctrl, exp_bank(13));
    check("pu_wr", core_o.pullup_ctrl, exp_bank(14));
    check("fr_wr", core_o.port_structure_ctrl, exp_bank(15));
    check("t1_wr", core_o.timer_one_ctrl, last_wr[5][3]);
    pc_value_i = 14'($random(seed)) | 14'h0001;
    pulse(pc_load_i);
    pulse(ext0_event_i);
    check("pc_ld", core_o.pc, pc_value_i);
    check("flags_set", {core_o.global_irq_allow, core_o.pd_flag,
          core_o.ext_zero_irq_request}, 16'h0007);
    do_reset();
    // Supervisor off with the pin low, comparators ignored.
    set_supply(1'b0, 1'b1, 1'b1, 1'b0);
    check("act_off", supervisor_active_o, 16'h0000);
    check("bo_off", supervisor_reset_o, 16'h0000);
    check("flag_off", low_voltage_flag_o, 16'h0000);
    pulse(hold_instr_i);
    @(negedge clk_i);
    power_down_i = 1'b1;
    settle();
    check("act_off_hold", supervisor_active_o, 16'h0000);
    power_down_i = 1'b0;
    do_reset();
    set_supply(1'b1, 1'b0, 1'b0, 1'b1);
    check("act_on", supervisor_active_o, 16'h0001);
    check("flag_lo", low_voltage_flag_o, 16'h0000);
    power_down_i = 1'b1;
    settle();
    check("act_pd", supervisor_active_o, 16'h0000);
    power_down_i = 1'b0;
    settle();
    check("act_back", supervisor_active_o, 16'h0001);
    pulse(hold_instr_i);
    power_down_i = 1'b1;
    settle();
    check("act_hold", supervisor_active_o, 16'h0001);
    power_down_i = 1'b0;
    do_reset();
    power_down_i = 1'b1;
    settle();
    check("hold_clr", supervisor_active_o, 16'h0000);
    power_down_i = 1'b0;
    // Random rows of the activity table, each from a fresh reset.
    for (int n = 0; n < 12; n++) begin
      rnd = 4'($random(seed));
      do_reset();
      set_supply(rnd[0], rnd[3], 1'b0, 1'b1);
      if (rnd[2])
        pulse(hold_instr_i);
      @(negedge clk_i);
      power_down_i = rnd[1];
      settle();
      exp_act = exp_active(rnd[0], rnd[1], rnd[2]);
      check("act_rnd", supervisor_active_o, exp_act);
      check("flag_rnd", low_voltage_flag_o, exp_act & rnd[3]);
      power_down_i = 1'b0;
    end
    // Low-voltage flag and repeated skip tests.
    set_supply(1'b1, 1'b1, 1'b0, 1'b1);
    check("flag_hi", low_voltage_flag_o, 16'h0001);
    for (int k = 0; k < 2; k++) begin
      @(negedge clk_i);
      skip_test_i = 1'b1;
      @(negedge clk_i);
      skip_test_i = 1'b0;
      check("skip", skip_next_o, 16'h0001);
      check("flag_kept", low_voltage_flag_o, 16'h0001);
      @(negedge clk_i);
      check("skip_end", skip_next_o, 16'h0000);
    end
    set_supply(1'b1, 1'b0, 1'b0, 1'b1);
    pulse(skip_test_i);
    check("noskip", skip_next_o, 16'h0000);
    // Brown-out reset forces the reset state and refuses writes.
    wr(SEL_OSC, 2'h0, 5'h03);
    wr_idle();
    set_supply(1'b1, 1'b1, 1'b1, 1'b0);
    check("bo_on", supervisor_reset_o, 16'h0001);
    check("osc_held", osc_enable_o, 16'h0000);
    wr(SEL_OSC, 2'h0, 5'h05);
    wr_idle();
    @(negedge clk_i);
    check_reset_state();
    @(negedge clk_i);
    supply_i = '{en_pin: 1'b1, skip: 1'b0, rst: 1'b0, release_ok: 1'b1};
    for (int w = 0; w < 10 && osc_enable_o !== 1'b1; w++)
      @(negedge clk_i);
    check("osc_first", osc_enable_o, 16'h0001);
    check("bo_still", supervisor_reset_o, 16'h0001);
    @(negedge clk_i);
    check("bo_rel", supervisor_reset_o, 16'h0000);
    // Losing the enable pin while held releases through the oscillator step.
    set_supply(1'b1, 1'b1, 1'b1, 1'b0);
    check("bo_on2", supervisor_reset_o, 16'h0001);
    set_supply(1'b0, 1'b1, 1'b1, 1'b0);
    check("osc_pin", osc_enable_o, 16'h0001);
    check("bo_pin", supervisor_reset_o, 16'h0001);
    @(negedge clk_i);
    check("bo_pin_rel", supervisor_reset_o, 16'h0000);
    complete_run();
  end
endmodule
